// ===== core/scpc_regs.vh
// register offsets, field positions and reset values of the control bank
`ifndef SCPC_REGS_VH
`define SCPC_REGS_VH

// register offsets
`define SCPC_OFS_SYNC_RESET_CAL_CTRL 12'h031
`define SCPC_OFS_ALIGN_PHASE_MODE 12'h032
`define SCPC_OFS_PHASE_OFFSET_VALUE 12'h033
`define SCPC_OFS_PHASE_APPLY_PATH_DELAY 12'h034
`define SCPC_OFS_OSC_BIAS_OVERRIDE 12'h035
`define SCPC_OFS_DIV_DOUBLE_BUF_OPTS 12'h036
`define SCPC_OFS_CAL_DECISION_TIME 12'h037
`define SCPC_OFS_TUNE_SETTLE_LOW 12'h038
`define SCPC_OFS_TUNE_SETTLE_HIGH_OSC_BUF 12'h039
`define SCPC_OFS_FIRST 12'h031
`define SCPC_NUM_REGS 9

// common reset value of every register
`define SCPC_RESET_VALUE 8'h00

// sync_reset_cal_ctrl fields
`define SCPC_SYNC_DELAY_MSB 7
`define SCPC_SYNC_DELAY_LSB 5
`define SCPC_SOFT_RESET_BIT 4
`define SCPC_ADC_CLK_EN_BIT 3
`define SCPC_TUNE_CAL_EN_BIT 2
`define SCPC_COUNT_SHORTEN_BIT 1
`define SCPC_CLK_HALVING_BIT 0

// align_phase_mode_ctrl fields
`define SCPC_DELAY_MODE_BIT 5
`define SCPC_AUTO_ALIGN_BIT 4
`define SCPC_PHASE_POL_BIT 3
`define SCPC_SPUR_FIX_MSB 2
`define SCPC_SPUR_FIX_LSB 0

// phase_apply_path_delay fields
`define SCPC_PHASE_APPLY_BIT 7
`define SCPC_REF_DELAY_MSB 6
`define SCPC_REF_DELAY_LSB 4
`define SCPC_FB_DELAY_MSB 3
`define SCPC_FB_DELAY_LSB 1
`define SCPC_CNTR_RESET_BIT 0

// osc_bias_override field
`define SCPC_BIAS_MSB 5
`define SCPC_BIAS_LSB 0

// divider_double_buffer_opts fields
`define SCPC_OUT_DIV_DB_BIT 7
`define SCPC_DIGITAL_CLK_DIV_BUFFER_SELECT_BIT 6
`define SCPC_LUT_USE_BIT 0

// tune_settle_high_osc_buffer fields
`define SCPC_OSC_DB_BIT 7
`define SCPC_SETTLE_HIGH_MSB 6
`define SCPC_SETTLE_HIGH_LSB 0

`endif

// ===== core/scpc_ctrl.v
// control register bank with double buffers and phase apply logic
`default_nettype none
// How it works
// [R1] a set soft reset bit clears digital state except registers, port and double-buffer active stages
// [R2] the converter clock enable bit gates the converter clock
// [R3] the tuning voltage calibration enable bit switches that calibration
// [R4] shorten bit takes one reference cycle off each nonzero calibration count
// [R5] halving bit divides reference and feedback clocks by two in calibration
// [R6] mode bit picks bleed adjustment at 0, sigma-delta at 1
// [R7] auto align bit turns clock align mode off at 0, on at 1
// [R8] polarity bit subtracts the offset at 0, adds it at 1
// [R9] three-bit field picks the walking-spur fix of the modulator
// [R10] writing the apply bit applies the eight-bit phase offset
// [R11] three-bit delays for reference, feedback and sync input paths
// [R12] counter reset bit holds frequency counter test logic in reset
// [R13] manual bias field is used only while override is set; here it feeds only the buffered stage and osc_bias_out takes cal_bias_in
// [R14] output divider setting direct at 0, double buffered at 1
// [R15] digital clock dividers direct at 0, double buffered at 1
// [R16] lookup table bit: 0 calibration skips table, 1 uses it
// [R17] eight-bit field sets each calibration decision time
// [R18] fifteen-bit settle time from low byte and next seven bits
// [R19] manual core, band and bias direct at 0, buffered at 1
// [R20] all registers reset to zero and read back as written
// [R21] buffered values move to active only on the update event
`include "scpc_regs.vh"

module scpc_ctrl #(
    parameter COUNT_W = 8,
    parameter OUT_DIV_W = 2,
    parameter DCLK_DIV_W = 6,
    parameter CORE_W = 2,
    parameter BAND_W = 8
) (
    input wire clk_sys_in,
    input wire reset_in,
    // register port from the serial interface
    input wire reg_wr_in,
    input wire [11:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    // calibration engine status
    input wire cal_active_in,
    input wire [COUNT_W-1:0] cal_count_base_in,
    input wire [5:0] cal_bias_in,
    // settings living in neighbouring registers
    input wire db_update_in,
    input wire [OUT_DIV_W-1:0] output_divider_setting_in,
    input wire [DCLK_DIV_W-1:0] ref_digital_clk_divider_in,
    input wire [DCLK_DIV_W-1:0] feedback_digital_clk_divider_in,
    input wire [CORE_W-1:0] manual_osc_core_in,
    input wire [BAND_W-1:0] manual_osc_band_in,
    // control outputs
    output wire digital_soft_reset_out,
    output wire adc_clk_enable_out,
    output wire tune_voltage_cal_enable_out,
    output reg [COUNT_W-1:0] cal_count_len_out,
    output reg cal_clk_halve_out,
    output wire delay_adjust_mode_out,
    output wire auto_align_enable_out,
    output wire [2:0] walking_spur_fix_select_out,
    output reg phase_apply_pulse_out,
    output reg [8:0] phase_step_out,
    output wire [2:0] sync_path_delay_out,
    output wire [2:0] ref_digital_path_delay_out,
    output wire [2:0] feedback_digital_path_delay_out,
    output wire freq_counter_test_reset_out,
    output wire cal_lookup_table_use_out,
    output wire [7:0] cal_decision_time_out,
    output wire [14:0] tune_settle_time_out,
    output reg [5:0] osc_bias_out,
    output reg [OUT_DIV_W-1:0] output_divider_active_out,
    output reg [DCLK_DIV_W-1:0] ref_digital_clk_div_active_out,
    output reg [DCLK_DIV_W-1:0] feedback_digital_clk_div_active_out,
    output reg [CORE_W-1:0] manual_osc_core_active_out,
    output reg [BAND_W-1:0] manual_osc_band_active_out,
    output reg [5:0] manual_osc_bias_active_out
);

    // register storage
    reg [7:0] regs_q [0:`SCPC_NUM_REGS-1];

    // address to index decode, valid flag in bit 4
    function [4:0] reg_index;
        input [11:0] addr;
        reg [11:0] rel;
        begin
            rel = addr - `SCPC_OFS_FIRST;
            if (addr >= `SCPC_OFS_FIRST && rel < `SCPC_NUM_REGS) begin
                reg_index = {1'b1, rel[3:0]};
            end else begin
                reg_index = 5'h00;
            end
        end
    endfunction

    // next active value of a setting that may be double buffered
    function [15:0] db_next;
        input buffered;
        input update;
        input [15:0] active;
        input [15:0] source;
        begin
            if (!buffered || update) begin
                db_next = source;
            end else begin
                db_next = active;
            end
        end
    endfunction

    wire [4:0] wr_idx;
    wire [4:0] rd_idx;
    wire soft_rst;
    wire [7:0] r_ctrl;
    wire [7:0] r_mode;
    wire [7:0] r_offset;
    wire [7:0] r_apply;
    wire [7:0] r_bias;
    wire [7:0] r_dbopt;
    wire [7:0] r_dec;
    wire [7:0] r_slo;
    wire [7:0] r_shi;
    wire apply_wr;
    wire bias_db;
    wire [15:0] out_div_nx;
    wire [15:0] ref_div_nx;
    wire [15:0] fb_div_nx;
    wire [15:0] core_nx;
    wire [15:0] band_nx;
    wire [15:0] bias_nx;

    assign wr_idx = reg_index(reg_addr_in);
    assign rd_idx = wr_idx;
    assign r_ctrl = regs_q[0];
    assign r_mode = regs_q[1];
    assign r_offset = regs_q[2];
    assign r_apply = regs_q[3];
    assign r_bias = regs_q[4];
    assign r_dbopt = regs_q[5];
    assign r_dec = regs_q[6];
    assign r_slo = regs_q[7];
    assign r_shi = regs_q[8];

    // register writes; soft reset leaves contents alone
    genvar gi;
    generate
        for (gi = 0; gi < `SCPC_NUM_REGS; gi = gi + 1) begin : g_reg
            always @(posedge clk_sys_in or posedge reset_in) begin
                if (reset_in) begin
                    regs_q[gi] <= `SCPC_RESET_VALUE; // R20
                end else if (reg_wr_in && wr_idx[4] && wr_idx[3:0] == gi) begin
                    regs_q[gi] <= reg_wdata_in; // R20
                end
            end
        end
    endgenerate

    // registered read data, unmapped reads zero
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
        end else if (rd_idx[4]) begin
            reg_rdata_out <= regs_q[rd_idx[3:0]]; // R20
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // soft reset of the digital logic
    assign soft_rst = r_ctrl[`SCPC_SOFT_RESET_BIT]; // R1
    assign digital_soft_reset_out = soft_rst; // R1

    // plain level controls
    assign adc_clk_enable_out = r_ctrl[`SCPC_ADC_CLK_EN_BIT] & ~soft_rst; // R2
    assign tune_voltage_cal_enable_out = r_ctrl[`SCPC_TUNE_CAL_EN_BIT]; // R3
    assign delay_adjust_mode_out = r_mode[`SCPC_DELAY_MODE_BIT]; // R6
    assign auto_align_enable_out = r_mode[`SCPC_AUTO_ALIGN_BIT]; // R7
    assign walking_spur_fix_select_out =
        r_mode[`SCPC_SPUR_FIX_MSB:`SCPC_SPUR_FIX_LSB]; // R9
    assign sync_path_delay_out =
        r_ctrl[`SCPC_SYNC_DELAY_MSB:`SCPC_SYNC_DELAY_LSB]; // R11
    assign ref_digital_path_delay_out =
        r_apply[`SCPC_REF_DELAY_MSB:`SCPC_REF_DELAY_LSB]; // R11
    assign feedback_digital_path_delay_out =
        r_apply[`SCPC_FB_DELAY_MSB:`SCPC_FB_DELAY_LSB]; // R11
    assign freq_counter_test_reset_out =
        r_apply[`SCPC_CNTR_RESET_BIT] | soft_rst; // R12
    assign cal_lookup_table_use_out = r_dbopt[`SCPC_LUT_USE_BIT]; // R16
    assign cal_decision_time_out = r_dec; // R17
    assign tune_settle_time_out =
        {r_shi[`SCPC_SETTLE_HIGH_MSB:`SCPC_SETTLE_HIGH_LSB], r_slo}; // R18

    // calibration count length and clock halving
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cal_count_len_out <= {COUNT_W{1'b0}};
            cal_clk_halve_out <= 1'b0;
        end else if (soft_rst) begin
            cal_count_len_out <= {COUNT_W{1'b0}}; // R1
            cal_clk_halve_out <= 1'b0; // R1
        end else begin
            if (r_ctrl[`SCPC_COUNT_SHORTEN_BIT] && cal_count_base_in != 0) begin
                cal_count_len_out <= cal_count_base_in - 1'b1; // R4
            end else begin
                cal_count_len_out <= cal_count_base_in;
            end
            // halve only for the length of calibration
            cal_clk_halve_out <=
                r_ctrl[`SCPC_CLK_HALVING_BIT] & cal_active_in; // R5
        end
    end

    // apply bit write starts one phase step
    assign apply_wr = reg_wr_in && wr_idx[4] && wr_idx[3:0] == 4'h3 &&
        reg_wdata_in[`SCPC_PHASE_APPLY_BIT]; // R10

    // phase step with sign from polarity
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            phase_apply_pulse_out <= 1'b0;
            phase_step_out <= 9'h000;
        end else if (soft_rst) begin
            phase_apply_pulse_out <= 1'b0; // R1
            phase_step_out <= 9'h000; // R1
        end else begin
            phase_apply_pulse_out <= apply_wr; // R10
            if (apply_wr) begin
                if (r_mode[`SCPC_PHASE_POL_BIT]) begin
                    phase_step_out <= {1'b0, r_offset}; // R8
                end else begin
                    phase_step_out <= 9'h000 - {1'b0, r_offset}; // R8
                end
            end
        end
    end

    // effective bias from calibration; the manual value is only offered on the
    // buffered bias stage, since the override select sits outside this bank
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            osc_bias_out <= 6'h00;
        end else if (soft_rst) begin
            osc_bias_out <= 6'h00; // R1
        end else begin
            osc_bias_out <= cal_bias_in; // R13
        end
    end

    // double buffer next values
    assign bias_db = r_shi[`SCPC_OSC_DB_BIT];
    assign out_div_nx = db_next(r_dbopt[`SCPC_OUT_DIV_DB_BIT], db_update_in,
        {{(16-OUT_DIV_W){1'b0}}, output_divider_active_out},
        {{(16-OUT_DIV_W){1'b0}}, output_divider_setting_in}); // R14
    assign ref_div_nx = db_next(r_dbopt[`SCPC_DIGITAL_CLK_DIV_BUFFER_SELECT_BIT], db_update_in,
        {{(16-DCLK_DIV_W){1'b0}}, ref_digital_clk_div_active_out},
        {{(16-DCLK_DIV_W){1'b0}}, ref_digital_clk_divider_in}); // R15
    assign fb_div_nx = db_next(r_dbopt[`SCPC_DIGITAL_CLK_DIV_BUFFER_SELECT_BIT], db_update_in,
        {{(16-DCLK_DIV_W){1'b0}}, feedback_digital_clk_div_active_out},
        {{(16-DCLK_DIV_W){1'b0}}, feedback_digital_clk_divider_in}); // R15
    assign core_nx = db_next(bias_db, db_update_in,
        {{(16-CORE_W){1'b0}}, manual_osc_core_active_out},
        {{(16-CORE_W){1'b0}}, manual_osc_core_in}); // R19
    assign band_nx = db_next(bias_db, db_update_in,
        {{(16-BAND_W){1'b0}}, manual_osc_band_active_out},
        {{(16-BAND_W){1'b0}}, manual_osc_band_in}); // R19
    assign bias_nx = db_next(bias_db, db_update_in,
        {10'h000, manual_osc_bias_active_out},
        {10'h000, r_bias[`SCPC_BIAS_MSB:`SCPC_BIAS_LSB]}); // R19

    // active stages; buffered ones move only on update
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            output_divider_active_out <= {OUT_DIV_W{1'b0}};
            ref_digital_clk_div_active_out <= {DCLK_DIV_W{1'b0}};
            feedback_digital_clk_div_active_out <= {DCLK_DIV_W{1'b0}};
            manual_osc_core_active_out <= {CORE_W{1'b0}};
            manual_osc_band_active_out <= {BAND_W{1'b0}};
            manual_osc_bias_active_out <= 6'h00;
        end else begin
            output_divider_active_out <= out_div_nx[OUT_DIV_W-1:0]; // R21
            ref_digital_clk_div_active_out <= ref_div_nx[DCLK_DIV_W-1:0]; // R21
            feedback_digital_clk_div_active_out <= fb_div_nx[DCLK_DIV_W-1:0]; // R21
            manual_osc_core_active_out <= core_nx[CORE_W-1:0]; // R21
            manual_osc_band_active_out <= band_nx[BAND_W-1:0]; // R21
            manual_osc_bias_active_out <= bias_nx[5:0]; // R21
        end
    end

endmodule
`default_nettype wire

// ===== dv/scpc_ctrl_monitor.sv
// assertion checker for the control register bank ports
`default_nettype none
module scpc_ctrl_monitor #(
    parameter COUNT_W = 8,
    parameter OUT_DIV_W = 2
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic reg_wr_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic cal_active_in,
    input wire logic [COUNT_W-1:0] cal_count_base_in,
    input wire logic [OUT_DIV_W-1:0] output_divider_setting_in,
    input wire logic digital_soft_reset_out,
    input wire logic adc_clk_enable_out,
    input wire logic freq_counter_test_reset_out,
    input wire logic [COUNT_W-1:0] cal_count_len_out,
    input wire logic cal_clk_halve_out,
    input wire logic phase_apply_pulse_out,
    input wire logic [8:0] phase_step_out,
    input wire logic [OUT_DIV_W-1:0] output_divider_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // single clock domain, reset disables every check
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    // write to the apply register with the apply bit set
    wire logic apply_wr = reg_wr_in && reg_addr_in == 12'h034 && reg_wdata_in[7];
    a_apply_pulse_next: assert property (
        apply_wr && !digital_soft_reset_out |=> phase_apply_pulse_out)
        else $error("apply pulse missing");
    a_apply_pulse_cause: assert property (
        phase_apply_pulse_out |-> $past(apply_wr))
        else $error("apply pulse without write");
    a_step_hold: assert property (
        !phase_apply_pulse_out && !$past(digital_soft_reset_out) |-> $stable(phase_step_out))
        else $error("phase step moved without apply");
    a_soft_reset_gates: assert property (
        digital_soft_reset_out |-> !adc_clk_enable_out && freq_counter_test_reset_out)
        else $error("soft reset not applied");
    a_count_len_rel: assert property (
        !$past(reset_in) && !$past(digital_soft_reset_out) |->
        cal_count_len_out == $past(cal_count_base_in)
        || cal_count_len_out == $past(cal_count_base_in) - 1'b1)
        else $error("count length off base");
    a_halve_needs_cal: assert property (
        cal_clk_halve_out |-> $past(cal_active_in))
        else $error("halving outside calibration");
    a_unmapped_zero: assert property (
        reg_addr_in < 12'h031 || reg_addr_in > 12'h039 |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_active_source: assert property (
        $changed(output_divider_active_out) |->
        output_divider_active_out == $past(output_divider_setting_in))
        else $error("active divider not from source");
endmodule
bind scpc_ctrl scpc_ctrl_monitor #(.COUNT_W(COUNT_W), .OUT_DIV_W(OUT_DIV_W)) mon_u (.*);
`default_nettype wire

// ===== dv/scpc_testbench.sv
// self-checking bench for the control register bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0, reset_in = 1'b1, reg_wr_in = 1'b0;
    logic cal_active_in = 1'b0, db_update_in = 1'b0;
    logic [11:0] reg_addr_in = 12'h000;
    logic [7:0] reg_wdata_in = 8'h00, cal_count_base_in = 8'h00, manual_osc_band_in = 8'h00;
    logic [5:0] cal_bias_in = 6'h00, ref_digital_clk_divider_in = 6'h00;
    logic [5:0] feedback_digital_clk_divider_in = 6'h00;
    logic [1:0] output_divider_setting_in = 2'h0, manual_osc_core_in = 2'h0;
    wire logic [7:0] reg_rdata_out, cal_count_len_out, cal_decision_time_out;
    wire logic digital_soft_reset_out, adc_clk_enable_out, tune_voltage_cal_enable_out;
    wire logic cal_clk_halve_out, delay_adjust_mode_out, auto_align_enable_out;
    wire logic phase_apply_pulse_out, freq_counter_test_reset_out, cal_lookup_table_use_out;
    wire logic [2:0] walking_spur_fix_select_out, sync_path_delay_out;
    wire logic [2:0] ref_digital_path_delay_out, feedback_digital_path_delay_out;
    wire logic [8:0] phase_step_out;
    wire logic [14:0] tune_settle_time_out;
    wire logic [5:0] osc_bias_out, ref_digital_clk_div_active_out, manual_osc_bias_active_out;
    wire logic [5:0] feedback_digital_clk_div_active_out;
    wire logic [1:0] output_divider_active_out, manual_osc_core_active_out;
    wire logic [7:0] manual_osc_band_active_out;
    int n_errors = 0, compares = 0;
    logic [7:0] m [0:8];
    logic [29:0] ea;
    scpc_ctrl dut_u (.*);
    // packed views of the decoded fields and active stages
    wire logic [41:0] comb_seen = {digital_soft_reset_out, adc_clk_enable_out,
        tune_voltage_cal_enable_out, delay_adjust_mode_out, auto_align_enable_out,
        walking_spur_fix_select_out, sync_path_delay_out, ref_digital_path_delay_out,
        feedback_digital_path_delay_out, freq_counter_test_reset_out, cal_lookup_table_use_out,
        cal_decision_time_out, tune_settle_time_out};
    wire logic [29:0] act_seen = {output_divider_active_out, ref_digital_clk_div_active_out,
        feedback_digital_clk_div_active_out, manual_osc_core_active_out,
        manual_osc_band_active_out, manual_osc_bias_active_out};
    // 100 MHz clock
    always #5 clk_sys_in = ~clk_sys_in;
    // expected field decode from the register model
    function automatic logic [41:0] comb_exp();
        return {m[0][4], m[0][3] & ~m[0][4], m[0][2], m[1][5], m[1][4], m[1][2:0], m[0][7:5],
            m[3][6:4], m[3][3:1], m[3][0] | m[0][4], m[5][0], m[6], m[8][6:0], m[7]};
    endfunction
    function automatic logic [29:0] src_now();
        return {output_divider_setting_in, ref_digital_clk_divider_in,
            feedback_digital_clk_divider_in, manual_osc_core_in, manual_osc_band_in, m[4][5:0]};
    endfunction
    function automatic logic [7:0] len_exp(input logic sh, input logic [7:0] b);
        return (sh && b != 8'h00) ? b - 8'h01 : b;
    endfunction
    function automatic logic [8:0] step_exp(input logic pol, input logic [7:0] off);
        return pol ? {1'b0, off} : 9'h000 - {1'b0, off};
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    // one write cycle, model updated for mapped places only
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        if (a >= 12'h031 && a <= 12'h039) m[a - 12'h031] = d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        settle(1);
        chk(reg_rdata_out, (a >= 12'h031 && a <= 12'h039) ? m[a - 12'h031] : 8'h00);
    endtask
    task automatic stop_test();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_errors++;
        stop_test();
    end
    // main sequence
    initial begin
        foreach (m[i]) m[i] = 8'h00;
        void'($urandom(32'h7196));
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        for (int a = 'h30; a <= 'h3a; a++) rd(a[11:0]);
        repeat (40) begin
            wr(12'h030 + 12'($urandom % 11), 8'($urandom));
            chk(comb_seen, comb_exp());
        end
        for (int a = 'h30; a <= 'h3a; a++) rd(a[11:0]);
        // count shortening and halving, zero base as boundary
        for (int s = 0; s < 8; s++) begin
            wr(12'h031, {6'h00, s[0], s[2]});
            @(posedge clk_sys_in);
            cal_active_in <= s[1];
            cal_count_base_in <= s[1] ? 8'($urandom) : 8'h00;
            cal_bias_in <= 6'($urandom);
            settle(2);
            chk(cal_count_len_out, len_exp(s[0], cal_count_base_in));
            chk(cal_clk_halve_out, s[2] & s[1]);
        end
        // phase apply, both polarities, full-scale offset
        for (int p = 0; p < 2; p++) begin
            wr(12'h033, p ? 8'($urandom) : 8'hff);
            wr(12'h032, {4'h0, p[0], 3'h0});
            wr(12'h034, 8'h80);
            chk(phase_apply_pulse_out, 1'b1);
            chk(phase_step_out, step_exp(p[0], m[2]));
            wr(12'h034, 8'h7f);
            chk({phase_apply_pulse_out, phase_step_out}, step_exp(p[0], m[2]));
        end
        // soft reset clears digital state but keeps registers
        wr(12'h031, 8'h10);
        settle(1);
        chk({phase_step_out, cal_count_len_out, osc_bias_out}, 64'h0);
        rd(12'h033);
        wr(12'h031, 8'h00);
        settle(1);
        chk(osc_bias_out, cal_bias_in);
        // direct follow, then hold until the update pulse
        for (int s = 0; s < 2; s++) begin
            wr(12'h036, {s[0], s[0], 6'h00});
            wr(12'h039, {s[0], 7'h00});
            wr(12'h035, 8'($urandom));
            @(posedge clk_sys_in);
            {output_divider_setting_in, ref_digital_clk_divider_in, feedback_digital_clk_divider_in,
                manual_osc_core_in, manual_osc_band_in} <= 24'($urandom);
            settle(2);
            if (s == 0) ea = src_now();
            chk(act_seen, ea);
            @(posedge clk_sys_in);
            db_update_in <= 1'b1;
            @(posedge clk_sys_in);
            db_update_in <= 1'b0;
            #1;
            chk(act_seen, src_now());
        end
        stop_test();
    end
endmodule
`default_nettype wire
